// ==== logic/power_mgmt_status_regs.v ====
// power management configuration and controller status register bank
`timescale 1ns/1ps
`include "power_mgmt_defines.vh"
module power_mgmt_status_regs #(
    parameter COUNT_W = 8
) (
    input  wire                 clk,
    input  wire                 arst_n,
    input  wire                 ce,
    // register port from the serial interface, same clock
    input  wire [`ADDR_W-1:0]   reg_addr,
    input  wire                 reg_wr,
    input  wire [`DATA_W-1:0]   reg_wdata,
    input  wire                 reg_rd,
    output reg  [`DATA_W-1:0]   reg_rdata_r,
    output reg                  reg_rvalid_r,
    // status from the device core, same clock
    input  wire                 slow_osc_cal_done,
    input  wire                 slow_osc_cal_error,
    input  wire                 active_antenna,
    input  wire [6:0]           ctrl_state,
    input  wire                 tx_queue_full,
    input  wire [COUNT_W-1:0]   tx_queue_count,
    input  wire [COUNT_W-1:0]   rx_queue_count,
    input  wire                 radio_transmitting,
    // crystal status comes from the analog side, asynchronous
    input  wire                 crystal_running_pin,
    // controls toward the analog and power sections
    output reg                  internal_regulator_on_r,
    output reg                  regulator_clk_r,
    output reg                  battery_detect_on_r,
    output reg  [1:0]           battery_detect_threshold_r,
    output reg  [2:0]           regulator_level_applied_r,
    output reg                  linear_reg_bypass_r,
    output reg                  sleep_retain_fifo_r
);
    // configuration storage
    reg [`DATA_W-1:0] cfg4_r;   // external regulator select
    reg [`DATA_W-1:0] cfg3_r;   // multiplier enable, ratio upper bits
    reg [`DATA_W-1:0] cfg2_r;   // ratio lower bits
    reg [`DATA_W-1:0] cfg1_r;   // battery detector, level policy
    reg [`DATA_W-1:0] cfg0_r;   // regulator level, sleep select

    // decoded fields
    wire                 ext_reg_sel;
    wire                 rate_mult_enable;
    wire [`RATIO_W-1:0]  rate_mult_ratio;
    wire                 battery_detect_enable;
    wire [1:0]           battery_detect_threshold;
    wire                 regulator_level_policy;
    wire                 linear_reg_bypass;
    wire [2:0]           regulator_level;
    wire                 sleep_retain;
    wire                 crystal_running;

    assign ext_reg_sel              = cfg4_r[`BIT_EXT_REG_SEL];
    assign rate_mult_enable         = cfg3_r[`BIT_RATE_MULT_EN];
    assign rate_mult_ratio          = {cfg3_r[6:0], cfg2_r};
    assign battery_detect_enable    = cfg1_r[`BIT_BATT_EN];
    assign battery_detect_threshold = cfg1_r[`BIT_BATT_TH_HI:`BIT_BATT_TH_LO];
    assign regulator_level_policy   = cfg1_r[`BIT_LEVEL_POLICY];
    assign linear_reg_bypass        = cfg1_r[`BIT_LINEAR_BYPASS];
    assign regulator_level          = cfg0_r[`BIT_LEVEL_HI:`BIT_LEVEL_LO];
    assign sleep_retain             = cfg0_r[`BIT_SLEEP_RETAIN];

    // crystal level passes the pin synchroniser
    in_sync #(
        .RST_VAL (1'b1)
    ) u_xtal_sync (
        .clk     (clk),
        .arst_n  (arst_n),
        .ce      (ce),
        .pin     (crystal_running_pin),
        .level_r (crystal_running)
    );

    // status images assembled from core state
    wire [`DATA_W-1:0] status1;
    wire [`DATA_W-1:0] status0;
    wire               rx_empty;

    assign rx_empty = (rx_queue_count == {COUNT_W{1'b0}});
    // reserved bits 7:5 are tied to zero
    assign status1  = {3'h0,
                       slow_osc_cal_done,
                       active_antenna,
                       tx_queue_full,
                       rx_empty,
                       slow_osc_cal_error};
    assign status0  = {ctrl_state, crystal_running};

    // write path; masks keep reserved bits at reset value
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg4_r <= `RST_POWER_CONFIG_4;
            cfg3_r <= `RST_POWER_CONFIG_3;
            cfg2_r <= `RST_POWER_CONFIG_2;
            cfg1_r <= `RST_POWER_CONFIG_1;
            cfg0_r <= `RST_POWER_CONFIG_0;
        end else if (ce && reg_wr) begin
            case (reg_addr)
                `OFS_POWER_CONFIG_4: begin
                    cfg4_r <= (reg_wdata & `WMASK_POWER_CONFIG_4) |
                              (`RST_POWER_CONFIG_4 & ~`WMASK_POWER_CONFIG_4);
                end
                `OFS_POWER_CONFIG_3: begin
                    cfg3_r <= reg_wdata;
                end
                `OFS_POWER_CONFIG_2: begin
                    cfg2_r <= reg_wdata;
                end
                `OFS_POWER_CONFIG_1: begin
                    // bypass bit stored as written; keeping it zero is up to software
                    cfg1_r <= (reg_wdata & `WMASK_POWER_CONFIG_1) |
                              (`RST_POWER_CONFIG_1 & ~`WMASK_POWER_CONFIG_1);
                end
                `OFS_POWER_CONFIG_0: begin
                    cfg0_r <= (reg_wdata & `WMASK_POWER_CONFIG_0) |
                              (`RST_POWER_CONFIG_0 & ~`WMASK_POWER_CONFIG_0);
                end
                // status and counts and anything unmapped: write dropped
                default: begin
                    cfg0_r <= cfg0_r;
                end
            endcase
        end
    end

    // read path, data registered one cycle after the strobe
    reg [`DATA_W-1:0] rd_nxt;
    always @* begin
        rd_nxt = 8'h00;
        case (reg_addr)
            `OFS_POWER_CONFIG_4: rd_nxt = cfg4_r;
            `OFS_POWER_CONFIG_3: rd_nxt = cfg3_r;
            `OFS_POWER_CONFIG_2: rd_nxt = cfg2_r;
            `OFS_POWER_CONFIG_1: rd_nxt = cfg1_r;
            `OFS_POWER_CONFIG_0: rd_nxt = cfg0_r;
            `OFS_CTRL_STATUS_1:  rd_nxt = status1;
            `OFS_CTRL_STATUS_0:  rd_nxt = status0;
            `OFS_TX_QUEUE_LEVEL: rd_nxt = tx_queue_count[7:0];
            `OFS_RX_QUEUE_LEVEL: rd_nxt = rx_queue_count[7:0];
            // unmapped addresses read zero
            default:             rd_nxt = 8'h00;
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_r  <= 8'h00;
            reg_rvalid_r <= 1'b0;
        end else if (ce) begin
            reg_rvalid_r <= reg_rd;
            if (reg_rd) begin
                reg_rdata_r <= rd_nxt;
            end
        end
    end

    // regulator clock generator
    // fixed mode toggles every two cycles giving clk/4; multiplier mode uses a
    // phase accumulator whose carry rate is ratio/2^15, toggled for a half-rate
    // square wave, so the ratio is doubled into the accumulator to land on
    // ratio*clk/2^15 at the output
    reg [0:0]          div_cnt_r;      // fixed divider phase
    reg [`RATIO_W-1:0] acc_r;          // rate multiplier phase
    wire [`RATIO_W:0]  acc_sum;

    assign acc_sum = {1'b0, acc_r} + {rate_mult_ratio, 1'b0};

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt_r       <= 1'b0;
            acc_r           <= 15'h0000;
            regulator_clk_r <= 1'b0;
        end else if (ce) begin
            if (!rate_mult_enable) begin
                acc_r     <= 15'h0000;
                div_cnt_r <= div_cnt_r + 1'b1;
                if (div_cnt_r == 1'b1) begin
                    regulator_clk_r <= ~regulator_clk_r;
                end
            end else begin
                div_cnt_r <= 1'b0;
                acc_r     <= acc_sum[`RATIO_W-1:0];
                if (acc_sum[`RATIO_W]) begin
                    regulator_clk_r <= ~regulator_clk_r;
                end
            end
        end
    end

    // power controls toward the analog side
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            internal_regulator_on_r    <= 1'b1;
            battery_detect_on_r        <= 1'b0;
            battery_detect_threshold_r <= 2'h0;
            regulator_level_applied_r  <= 3'h0;
            linear_reg_bypass_r        <= 1'b0;
            sleep_retain_fifo_r        <= 1'b0;
        end else if (ce) begin
            internal_regulator_on_r    <= ~ext_reg_sel;
            battery_detect_on_r        <= battery_detect_enable;
            // code 0 is 2.7 V down to code 3 at 2.1 V; analog decodes it
            battery_detect_threshold_r <= battery_detect_threshold;
            linear_reg_bypass_r        <= linear_reg_bypass;
            sleep_retain_fifo_r        <= sleep_retain;
            if (regulator_level_policy && !radio_transmitting) begin
                // receive under policy set: fixed 1.4 V code
                regulator_level_applied_r <= `RX_FIXED_LEVEL;
            end else begin
                regulator_level_applied_r <= regulator_level;
            end
        end
    end
endmodule

// ==== logic/power_mgmt_defines.vh ====
// register offsets, field positions, reset values and constants of the power management bank
`ifndef POWER_MGMT_DEFINES_VH
`define POWER_MGMT_DEFINES_VH

`define ADDR_W                8
`define DATA_W                8

`define OFS_POWER_CONFIG_4    8'h75
`define OFS_POWER_CONFIG_3    8'h76
`define OFS_POWER_CONFIG_2    8'h77
`define OFS_POWER_CONFIG_1    8'h78
`define OFS_POWER_CONFIG_0    8'h79
`define OFS_CTRL_STATUS_1     8'h8D
`define OFS_CTRL_STATUS_0     8'h8E
`define OFS_TX_QUEUE_LEVEL    8'h8F
`define OFS_RX_QUEUE_LEVEL    8'h90

`define RST_POWER_CONFIG_4    8'h17
`define RST_POWER_CONFIG_3    8'h20
`define RST_POWER_CONFIG_2    8'h00
`define RST_POWER_CONFIG_1    8'h39
`define RST_POWER_CONFIG_0    8'h42
`define RST_CTRL_STATUS_1     8'h52
`define RST_CTRL_STATUS_0     8'h07

// writable bit masks; the rest keeps its reset value
`define WMASK_POWER_CONFIG_4  8'h20
`define WMASK_POWER_CONFIG_3  8'hFF
`define WMASK_POWER_CONFIG_2  8'hFF
`define WMASK_POWER_CONFIG_1  8'h7C
`define WMASK_POWER_CONFIG_0  8'h71

`define BIT_EXT_REG_SEL       5
`define BIT_RATE_MULT_EN      7
`define BIT_BATT_EN           6
`define BIT_BATT_TH_HI        5
`define BIT_BATT_TH_LO        4
`define BIT_LEVEL_POLICY      3
`define BIT_LINEAR_BYPASS     2
`define BIT_LEVEL_HI          6
`define BIT_LEVEL_LO          4
`define BIT_SLEEP_RETAIN      0

`define BIT_CAL_DONE          4
`define BIT_ANTENNA           3
`define BIT_TX_FULL           2
`define BIT_RX_EMPTY          1
`define BIT_CAL_ERROR         0

`define RATIO_W               15
`define FIXED_DIV             4
`define RX_FIXED_LEVEL        3'h3

`endif

// ==== logic/in_sync.v ====
// three-stage synchroniser for one pin level, change taken when stages two and three agree
`timescale 1ns/1ps
module in_sync #(
    parameter RST_VAL = 1'b0
) (
    input  wire clk,
    input  wire arst_n,
    input  wire ce,
    input  wire pin,
    output reg  level_r
);
    reg s1_r;  // first stage, read only by s2
    reg s2_r;
    reg s3_r;

    // shift chain and agreement filter
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_r    <= RST_VAL;
            s2_r    <= RST_VAL;
            s3_r    <= RST_VAL;
            level_r <= RST_VAL;
        end else if (ce) begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // take a new level only when two later stages agree
            if (s2_r == s3_r) begin
                level_r <= s3_r;
            end
        end
    end
endmodule

// ==== dv/power_mgmt_status_regs_asserts.sv ====
// port-level assertions for the power management register bank
`timescale 1ns/1ps
module power_mgmt_status_regs_chk #(
    parameter COUNT_W = 8
) (
    input wire               clk,
    input wire               arst_n,
    input wire               ce,
    input wire [7:0]         reg_addr,
    input wire               reg_wr,
    input wire [7:0]         reg_wdata,
    input wire               reg_rd,
    input wire [7:0]         reg_rdata_r,
    input wire               reg_rvalid_r,
    input wire               slow_osc_cal_done,
    input wire               slow_osc_cal_error,
    input wire               active_antenna,
    input wire               tx_queue_full,
    input wire [COUNT_W-1:0] tx_queue_count,
    input wire [COUNT_W-1:0] rx_queue_count,
    input wire               radio_transmitting,
    input wire               internal_regulator_on_r,
    input wire               battery_detect_on_r,
    input wire [2:0]         regulator_level_applied_r
);
    reg        ext_r;  // shadow of external regulator select
    reg        bat_r;  // shadow of detector enable
    reg        pol_r;  // shadow of level policy
    reg  [2:0] lvl_r;  // shadow of programmed level
    // shadows follow host writes so outputs can be predicted from ports alone
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ext_r <= 1'b0;
            bat_r <= 1'b0;
            pol_r <= 1'b1;
            lvl_r <= 3'h4;
        end else if (ce && reg_wr) begin
            if (reg_addr == 8'h75) ext_r <= reg_wdata[5];
            if (reg_addr == 8'h78) bat_r <= reg_wdata[6];
            if (reg_addr == 8'h78) pol_r <= reg_wdata[3];
            if (reg_addr == 8'h79) lvl_r <= reg_wdata[6:4];
        end
    end
    // receive with policy set forces the fixed level
    wire [2:0] lvl_exp = (pol_r && !radio_transmitting) ? 3'h3 : lvl_r;
    wire [7:0] st1     = {3'h0, slow_osc_cal_done, active_antenna, tx_queue_full,
                          rx_queue_count == 0, slow_osc_cal_error};
    default clocking @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    property p_rd_valid; ce && reg_rd |=> reg_rvalid_r; endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
    property p_no_valid; !(ce && reg_rd) |=> !reg_rvalid_r; endproperty
    a_no_valid: assert property (p_no_valid) else $error("valid without read");
    property p_rdata_hold; !reg_rvalid_r |-> $stable(reg_rdata_r); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_status1; ce && reg_rd && reg_addr == 8'h8D |=> reg_rdata_r == $past(st1); endproperty
    a_status1: assert property (p_status1) else $error("status one wrong");
    property p_tx_level; ce && reg_rd && reg_addr == 8'h8F |=> reg_rdata_r == $past(tx_queue_count); endproperty
    a_tx_level: assert property (p_tx_level) else $error("tx count wrong");
    property p_rx_level; ce && reg_rd && reg_addr == 8'h90 |=> reg_rdata_r == $past(rx_queue_count); endproperty
    a_rx_level: assert property (p_rx_level) else $error("rx count wrong");
    property p_reg_off; $past(arst_n) |-> internal_regulator_on_r == !$past(ext_r); endproperty
    a_reg_off: assert property (p_reg_off) else $error("regulator enable wrong");
    property p_batt; $past(arst_n) |-> battery_detect_on_r == $past(bat_r); endproperty
    a_batt: assert property (p_batt) else $error("detector enable wrong");
    property p_level; $past(arst_n) |-> regulator_level_applied_r == $past(lvl_exp); endproperty
    a_level: assert property (p_level) else $error("applied level wrong");
endmodule
bind power_mgmt_status_regs power_mgmt_status_regs_chk #(.COUNT_W(COUNT_W)) chk_i (
    .clk(clk), .arst_n(arst_n), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
    .reg_rvalid_r(reg_rvalid_r), .slow_osc_cal_done(slow_osc_cal_done),
    .slow_osc_cal_error(slow_osc_cal_error), .active_antenna(active_antenna),
    .tx_queue_full(tx_queue_full), .tx_queue_count(tx_queue_count),
    .rx_queue_count(rx_queue_count), .radio_transmitting(radio_transmitting),
    .internal_regulator_on_r(internal_regulator_on_r),
    .battery_detect_on_r(battery_detect_on_r),
    .regulator_level_applied_r(regulator_level_applied_r));

// ==== dv/test_power_mgmt_status_regs.sv ====
// self-checking bench for the power management register bank
`timescale 1ns/1ps
`include "power_mgmt_defines.vh"
module test_power_mgmt_status_regs;
    localparam [39:0] rst_vals = {`RST_POWER_CONFIG_4, `RST_POWER_CONFIG_3,
        `RST_POWER_CONFIG_2, `RST_POWER_CONFIG_1, `RST_POWER_CONFIG_0};
    localparam [39:0] wr_masks = {`WMASK_POWER_CONFIG_4, `WMASK_POWER_CONFIG_3,
        `WMASK_POWER_CONFIG_2, `WMASK_POWER_CONFIG_1, `WMASK_POWER_CONFIG_0};
    reg         clk = 1'b0;  // 100 MHz
    reg         arst_n, ce, reg_wr, reg_rd, cal_done, cal_err, ant, tx_full, radio_tx, xtal;
    reg  [7:0]  reg_addr, reg_wdata, tx_cnt, rx_cnt, d;
    reg  [6:0]  ctrl_state;
    reg  [31:0] lf;          // random source
    reg  [7:0]  exp_q[$];    // pending read results, oldest first
    wire [7:0]  rdata;
    wire [2:0]  lvl;
    wire [1:0]  thr;
    wire        rvalid, reg_on, reg_clk, bat_on, bypass, retain;
    integer     error_cnt = 0, total_checks = 0, i;
    always #5 clk = ~clk;
    power_mgmt_status_regs power_mgmt_status_regs_i (
        .clk(clk), .arst_n(arst_n), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_r(rdata), .reg_rvalid_r(rvalid),
        .slow_osc_cal_done(cal_done), .slow_osc_cal_error(cal_err), .active_antenna(ant),
        .ctrl_state(ctrl_state), .tx_queue_full(tx_full), .tx_queue_count(tx_cnt),
        .rx_queue_count(rx_cnt), .radio_transmitting(radio_tx), .crystal_running_pin(xtal),
        .internal_regulator_on_r(reg_on), .regulator_clk_r(reg_clk),
        .battery_detect_on_r(bat_on), .battery_detect_threshold_r(thr),
        .regulator_level_applied_r(lvl), .linear_reg_bypass_r(bypass),
        .sleep_retain_fifo_r(retain));
    function [31:0] nx(input [31:0] v);
        nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task chk(input string nm, input [7:0] e, input [7:0] s);
        begin
            total_checks = total_checks + 1;
            if (s !== e) begin
                error_cnt = error_cnt + 1;
                $display("MISMATCH %s expected %h seen %h", nm, e, s);
            end
        end
    endtask
    // one register cycle; a read notes its expected data for the monitor
    // an idle edge first, so back-to-back calls never drive a strobe twice in one step
    task acc(input w, input [7:0] a, input [7:0] v);
        begin
            @(posedge clk) #1;
            if (!w) exp_q.push_back(v);
            reg_addr = a;
            reg_wdata = v;
            {reg_wr, reg_rd} = {w, !w};
            @(posedge clk) #1 {reg_wr, reg_rd} = 2'b00;
        end
    endtask
    // counts regulator clock changes over n cycles
    task cnt_tog(input integer n, input [7:0] e);
        integer k;
        reg [7:0] t;
        reg p;
        begin
            t = 8'h00;
            p = reg_clk;
            for (k = 0; k < n; k = k + 1) begin
                @(posedge clk) #1 t = t + {7'h0, reg_clk !== p};
                p = reg_clk;
            end
            chk("regclk_toggles", e, t);
        end
    endtask
    task results;
        begin
            $display("checks %0d errors %0d", total_checks, error_cnt);
            if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    // monitor pairs each read answer with the oldest note
    always @(posedge clk) begin
        #1;
        if (rvalid === 1'b1) chk("rdata", exp_q.pop_front(), rdata);
    end
    // whole run is near 460 cycles; this cuts a hang
    initial begin
        #200000;
        error_cnt = error_cnt + 1;
        results;
    end
    initial begin
        {arst_n, reg_wr, reg_rd, cal_done, cal_err, ant, tx_full, radio_tx} = 8'h00;
        {reg_addr, reg_wdata, tx_cnt, rx_cnt, ctrl_state} = 39'h0;
        ce = 1'b1;
        xtal = 1'b1;
        lf = 32'h36C984B3;
        repeat (5) @(posedge clk);
        #1 arst_n = 1'b1;
        for (i = 0; i < 5; i = i + 1) acc(0, 8'h75 + i[2:0], rst_vals[39-8*i -: 8]);
        acc(0, 8'h50, 8'h00);
        cnt_tog(40, 8'd20);
        acc(1, 8'h76, 8'h88);
        acc(1, 8'h77, 8'h00);
        repeat (20) @(posedge clk);
        #1 cnt_tog(160, 8'd20);
        for (i = 0; i < 5; i = i + 1) begin
            lf = nx(lf);
            d = (i == 3) ? lf[7:0] & 8'hFB : lf[7:0];
            acc(1, 8'h75 + i[2:0], d);
            acc(0, 8'h75 + i[2:0], (rst_vals[39-8*i -: 8] & ~wr_masks[39-8*i -: 8])
                | (d & wr_masks[39-8*i -: 8]));
        end
        // every threshold code, both policies, receive and transmit
        for (i = 0; i < 8; i = i + 1) begin
            acc(1, 8'h75, {2'h0, i[0], 5'h00});
            acc(1, 8'h78, {1'b0, i[0], i[1:0], i[2], 3'h0});
            acc(1, 8'h79, {2'h1, i[1:0], 3'h0, i[1]});
            radio_tx = i[1];
            repeat (2) @(posedge clk);
            #1 chk("reg_on", {7'h0, ~i[0]}, {7'h0, reg_on});
            chk("bat_on", {7'h0, i[0]}, {7'h0, bat_on});
            chk("threshold", {6'h0, i[1:0]}, {6'h0, thr});
            chk("level", (i[2] && !i[1]) ? 8'h03 : {6'h1, i[1:0]}, {5'h0, lvl});
            chk("retain", {7'h0, i[1]}, {7'h0, retain});
            chk("bypass", 8'h00, {7'h0, bypass});
        end
        // a write while the clock enable is low must not land
        ce = 1'b0;
        acc(1, 8'h75, 8'h00);
        ce = 1'b1;
        acc(0, 8'h75, 8'h37);
        // live status with writes to read-only places in between
        for (i = 0; i < 8; i = i + 1) begin
            lf = nx(lf);
            {cal_done, cal_err, ant, tx_full, radio_tx, ctrl_state} = lf[11:0];
            tx_cnt = lf[23:16];
            rx_cnt = i[0] ? lf[31:24] : 8'h00;
            xtal = ~xtal;
            acc(1, 8'h8D + i[1:0], 8'hFF);
            repeat (6) @(posedge clk);
            #1 acc(0, 8'h8D, {3'h0, cal_done, ant, tx_full, rx_cnt == 8'h00, cal_err});
            acc(0, 8'h8F, tx_cnt);
            acc(0, 8'h90, rx_cnt);
            acc(0, 8'h8E, {ctrl_state, xtal});
        end
        repeat (3) @(posedge clk);
        #1 chk("pending_reads", 8'h00, exp_q.size());
        results;
    end
endmodule
